// ---- common/ats_pkg.sv ----
// Purpose: constants for the acceleration data, sensor time and status register group
// Assumes: Avalon-MM slave, 32-bit data, register offsets are word indices
// Notes: byte address is four times the index
package ats_pkg;
   // ----------------------------------------------------------------
   // register indices
   // ----------------------------------------------------------------
   localparam logic [5:0] IDX_ACCEL_Y_LOW = 6'h14;
   localparam logic [5:0] IDX_ACCEL_Y_HIGH = 6'h15;
   localparam logic [5:0] IDX_ACCEL_Z_LOW = 6'h16;
   localparam logic [5:0] IDX_ACCEL_Z_HIGH = 6'h17;
   localparam logic [5:0] IDX_TIME_BYTE0 = 6'h18;
   localparam logic [5:0] IDX_TIME_BYTE1 = 6'h19;
   localparam logic [5:0] IDX_TIME_BYTE2 = 6'h1A;
   localparam logic [5:0] IDX_EVENT = 6'h1B;
   localparam logic [5:0] IDX_FEATURE_FLAGS = 6'h1C;
   localparam logic [5:0] IDX_FIFO_FLAGS = 6'h1D;
   localparam logic [5:0] IDX_IRQ_ENABLE = 6'h30;
   localparam logic [5:0] IDX_IRQ_STATUS = 6'h31;
   localparam logic [5:0] IDX_IRQ_CLEAR = 6'h32;
   // ----------------------------------------------------------------
   // field layouts and reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] FEATURE_MASK = 8'hEE;
   localparam logic [7:0] FIFO_MASK = 8'hA3;
   localparam logic [7:0] EVENT_RESET = 8'h01;
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam int POR_BIT = 0;
   localparam int IRQ_WIDTH = 3;
   localparam int IRQ_POR_BIT = 0;
   localparam int IRQ_FEATURE_BIT = 1;
   localparam int IRQ_FIFO_BIT = 2;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam real CLK_PERIOD_NS = 8.0;
   localparam real TIME_LSB_NS = 39062.5;
   localparam int TICK_CYCLES = int'(TIME_LSB_NS / CLK_PERIOD_NS);
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
endpackage

// ---- common/ats_bus_if.sv ----
// Purpose: internal read strobe carrier between bus slave and status flags
// Assumes: single clock
// Notes: read_clear pulses one cycle per completed read
`timescale 1ns/1ps
interface ats_bus_if;
   logic read_clear_feature;
   logic read_clear_fifo;
   logic read_clear_event;
   modport master (output read_clear_feature, output read_clear_fifo, output read_clear_event);
   modport flags (input read_clear_feature, input read_clear_fifo, input read_clear_event);
endinterface

// ---- rtl/ats_time_counter.sv ----
// Purpose: free-running 24-bit sensor time
// Assumes: tick every TICK_CYCLES clocks
// Notes: wraps at full scale
`timescale 1ns/1ps
module ats_time_counter
   import ats_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   output logic [23:0] time_count
);
   logic [31:0] prescale_q;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         prescale_q <= 32'h0;
      end else if (prescale_q == 32'(TICK_CYCLES - 1)) begin
         prescale_q <= 32'h0;
      end else begin
         prescale_q <= prescale_q + 32'h1;
      end
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         time_count <= 24'h0;
      end else if (prescale_q == 32'(TICK_CYCLES - 1)) begin
         time_count <= time_count + 24'h1;
      end
   end
endmodule

// ---- rtl/ats_regs.sv ----
// Purpose: acceleration data, sensor time and clear-on-read status registers
// Assumes: event and data inputs are synchronous to clk
// Notes: Avalon-MM slave, one wait state per access
//
// Functional notes
// - index 0x15 reads Y acceleration bits 11..4 and resets to zero.
// - index 0x16 holds Z bits 3..0 in the upper nibble, lower nibble zero.
// - index 0x17 reads Z acceleration bits 11..4 and resets to zero.
// - a 24-bit sensor time counts in 39.0625 us steps, low byte at 0x18.
// - sensor time bits 15..8 read at index 0x19.
// - sensor time bits 23..16 read at index 0x1A, all time bytes reset to zero.
// - event bit 0 is one after reset and clears when read.
// - reading index 0x1C clears all feature flags not set again in that cycle.
// - feature flags sit at bits 1,2,3,5,6,7, bits 0 and 4 reserved.
// - reading index 0x1D clears all its flags not set again in that cycle, reset zero.
// - fifo full bit 0, watermark bit 1, aux ready bit 5, accel ready bit 7.
// - index 0x14 holds Y bits 3..0 in the upper nibble.
`timescale 1ns/1ps
module ats_regs
   import ats_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [11:0] accel_y,
   input wire logic [11:0] accel_z,
   input wire logic data_update,
   input wire logic [7:0] feature_events,
   input wire logic [7:0] fifo_events,
   output logic irq
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   ats_bus_if rd_if ();
   logic [23:0] time_count;
   logic [11:0] accel_y_q;
   logic [11:0] accel_z_q;
   logic [7:0] event_q;
   logic [7:0] feature_q;
   logic [7:0] fifo_q;
   logic [IRQ_WIDTH-1:0] irq_status_q;
   logic [IRQ_WIDTH-1:0] irq_enable_q;
   logic ack_q;
   logic [5:0] idx;
   logic rd_fire;
   logic wr_fire;
   logic [7:0] rd_byte;
   logic [IRQ_WIDTH-1:0] irq_set;
   logic [IRQ_WIDTH-1:0] irq_clr;

   function automatic logic [7:0] sticky(input logic [7:0] cur, input logic [7:0] ev,
                                          input logic clr, input logic [7:0] mask);
      sticky = ((clr ? 8'h00 : cur) | ev) & mask;
   endfunction

   ats_time_counter u_time (
      .clk(clk),
      .reset_n(reset_n),
      .time_count(time_count)
   );

   assign idx = avs_address[7:2];
   assign rd_fire = avs_read && ack_q;
   assign wr_fire = avs_write && ack_q;
   assign rd_if.read_clear_feature = rd_fire && idx == IDX_FEATURE_FLAGS;
   assign rd_if.read_clear_fifo = rd_fire && idx == IDX_FIFO_FLAGS;
   assign rd_if.read_clear_event = rd_fire && idx == IDX_EVENT;

   // ----------------------------------------------------------------
   // bus handshake
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (avs_read || avs_write) && !ack_q;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= !((avs_read || avs_write) && !ack_q);
      end
   end

   // ----------------------------------------------------------------
   // data capture
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         accel_y_q <= 12'h0;
         accel_z_q <= 12'h0;
      end else if (data_update) begin
         accel_y_q <= accel_y;
         accel_z_q <= accel_z;
      end
   end

   // ----------------------------------------------------------------
   // clear-on-read flags
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         event_q <= EVENT_RESET;
      end else if (rd_if.read_clear_event) begin
         event_q <= 8'h00;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         feature_q <= FLAGS_RESET;
      end else begin
         feature_q <= sticky(feature_q, feature_events, rd_if.read_clear_feature,
                             FEATURE_MASK);
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         fifo_q <= FLAGS_RESET;
      end else begin
         fifo_q <= sticky(fifo_q, fifo_events, rd_if.read_clear_fifo,
                          FIFO_MASK);
      end
   end

   // ----------------------------------------------------------------
   // interrupt
   // ----------------------------------------------------------------
   assign irq_set = {|(fifo_events & FIFO_MASK), |(feature_events & FEATURE_MASK), 1'b0};
   assign irq_clr = (wr_fire && idx == IDX_IRQ_CLEAR && avs_byteenable[0]) ?
                    avs_writedata[IRQ_WIDTH-1:0] : '0;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_status_q <= '0;
         irq_status_q[IRQ_POR_BIT] <= 1'b1;
      end else begin
         irq_status_q <= (irq_status_q & ~irq_clr) | irq_set;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_enable_q <= '0;
      end else if (wr_fire && idx == IDX_IRQ_ENABLE && avs_byteenable[0]) begin
         irq_enable_q <= avs_writedata[IRQ_WIDTH-1:0];
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         irq <= 1'b0;
      end else begin
         irq <= |(((irq_status_q & ~irq_clr) | irq_set) & irq_enable_q);
      end
   end

   // ----------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------
   always_comb begin
      rd_byte = UNMAPPED_READ;
      unique case (idx)
         IDX_ACCEL_Y_LOW: rd_byte = {accel_y_q[3:0], 4'h0};
         IDX_ACCEL_Y_HIGH: rd_byte = accel_y_q[11:4];
         IDX_ACCEL_Z_LOW: rd_byte = {accel_z_q[3:0], 4'h0};
         IDX_ACCEL_Z_HIGH: rd_byte = accel_z_q[11:4];
         IDX_TIME_BYTE0: rd_byte = time_count[7:0];
         IDX_TIME_BYTE1: rd_byte = time_count[15:8];
         IDX_TIME_BYTE2: rd_byte = time_count[23:16];
         IDX_EVENT: rd_byte = event_q;
         IDX_FEATURE_FLAGS: rd_byte = feature_q;
         IDX_FIFO_FLAGS: rd_byte = fifo_q;
         IDX_IRQ_ENABLE: rd_byte = {5'h0, irq_enable_q};
         IDX_IRQ_STATUS: rd_byte = {5'h0, irq_status_q};
         default: rd_byte = UNMAPPED_READ;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         avs_readdata <= 32'h0;
      end else if (avs_read && !ack_q) begin
         avs_readdata <= {24'h0, rd_byte};
      end
   end
endmodule

// ---- verification/ats_regs_assertions.sv ----
// Purpose: readback checks on the register group
// Assumes: readdata valid while waitrequest low
// Notes: bound onto ats_regs
`timescale 1ns/1ps
module ats_regs_assertions (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [11:0] accel_y,
   input wire logic [11:0] accel_z,
   input wire logic data_update
);
   logic [11:0] y_cap_q;
   logic [11:0] z_cap_q;
   wire logic rd = avs_read && !avs_waitrequest;
   wire logic [7:0] d = avs_readdata[7:0];
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // last captured sample, as the registers hold it
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         y_cap_q <= 12'h000;
         z_cap_q <= 12'h000;
      end else if (data_update) begin
         y_cap_q <= accel_y;
         z_cap_q <= accel_z;
      end
   end
   a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("wait low too long");
   a_wait_answer: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
      else $error("no answer");
   a_upper_zero: assert property (rd |-> avs_readdata[31:8] == 24'h0)
      else $error("upper lanes set");
   a_y_low: assert property (rd && avs_address == 8'h50 |-> d == {$past(y_cap_q[3:0]), 4'h0})
      else $error("y low wrong");
   a_y_high: assert property (rd && avs_address == 8'h54 |-> d == $past(y_cap_q[11:4]))
      else $error("y high wrong");
   a_z_low: assert property (rd && avs_address == 8'h58 |-> d == {$past(z_cap_q[3:0]), 4'h0})
      else $error("z low wrong");
   a_z_high: assert property (rd && avs_address == 8'h5C |-> d == $past(z_cap_q[11:4]))
      else $error("z high wrong");
   a_fifo_resv: assert property (rd && avs_address == 8'h74 |-> (d & 8'h5C) == 8'h0)
      else $error("fifo reserved set");
   a_event_resv: assert property (rd && avs_address == 8'h6C |-> d[7:1] == 7'h0)
      else $error("event reserved set");
   a_flag_resv: assert property (rd && avs_address == 8'h70 |-> (d & 8'h11) == 8'h0)
      else $error("feature reserved set");
endmodule
bind ats_regs ats_regs_assertions chk (.clk(clk), .reset_n(reset_n),
   .avs_address(avs_address), .avs_read(avs_read), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .accel_y(accel_y), .accel_z(accel_z),
   .data_update(data_update));

// ---- verification/ats_host_model.sv ----
// Purpose: host bus master for register accesses
// Assumes: request held until waitrequest low
// Notes: one idle cycle after each access
`timescale 1ns/1ps
module ats_host_model (
   input wire logic clk,
   output logic [7:0] avs_address,
   output logic avs_read,
   output logic avs_write,
   output logic [31:0] avs_writedata,
   output logic [3:0] avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest
);
   initial begin
      avs_address = 8'h00;
      avs_read = 1'h0;
      avs_write = 1'h0;
      avs_writedata = 32'h0;
      avs_byteenable = 4'hF;
   end
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] q);
      avs_address <= a;
      avs_writedata <= wd;
      avs_read <= !w;
      avs_write <= w;
      do @(posedge clk); while (avs_waitrequest !== 1'h0);
      q = avs_readdata;
      avs_read <= 1'h0;
      avs_write <= 1'h0;
      @(posedge clk);
   endtask
endmodule

// ---- verification/ats_regs_tb.sv ----
// Purpose: self-checking bench for the register group
// Assumes: host model makes all bus cycles
// Notes: sensor time read half way into the fourth tick
`timescale 1ns/1ps
module ats_regs_tb
   import ats_pkg::*;
;
   logic clk, reset_n, du, irq, rq, wr, wt;
   logic [11:0] ay, az;
   logic [7:0] fe, fi, ad;
   logic [31:0] wd, rdd, q;
   logic [3:0] be;
   logic [15:0] rows [5] = '{16'h50C0, 16'h54AB, 16'h5870, 16'h5C5D, 16'hFC00};
   int n_errors = 0;
   int compares = 0;
   int cyc = 0;
   ats_regs dut (.clk(clk), .reset_n(reset_n), .avs_address(ad), .avs_read(rq),
      .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdd),
      .avs_waitrequest(wt), .accel_y(ay), .accel_z(az), .data_update(du),
      .feature_events(fe), .fifo_events(fi), .irq(irq));
   ats_host_model host (.clk(clk), .avs_address(ad), .avs_read(rq), .avs_write(wr),
      .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdd), .avs_waitrequest(wt));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] exp);
      host.acc(1'h0, a, 32'h0, q);
      chk(q, exp);
   endtask
   task automatic pulse(input logic [7:0] f0, input logic [7:0] f1);
      fe <= f0;
      fi <= f1;
      @(posedge clk);
      fe <= 8'h00;
      fi <= 8'h00;
      repeat (2) @(posedge clk);
   endtask
   task automatic stop_test();
      if (n_errors == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      clk = 1'h0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_errors++;
         stop_test();
      end
   end
   initial begin
      reset_n = 1'h0;
      du = 1'h0;
      ay = 12'h000;
      az = 12'h000;
      fe = 8'h00;
      fi = 8'h00;
      repeat (5) @(posedge clk);
      reset_n <= 1'h1;
      repeat (TICK_CYCLES * 3 + TICK_CYCLES / 2) @(posedge clk);
      rc(8'h60, 32'h03);
      rc(8'h64, 32'h00);
      rc(8'h68, 32'h00);
      rc(8'h6C, 32'h01);
      rc(8'h6C, 32'h00);
      rc(8'h74, 32'h00);
      ay <= 12'hABC;
      az <= 12'h5D7;
      du <= 1'h1;
      @(posedge clk);
      du <= 1'h0;
      host.acc(1'h1, 8'h54, 32'hFF, q);
      foreach (rows[i]) rc(rows[i][15:8], {24'h0, rows[i][7:0]});
      pulse(8'hFF, 8'hFF);
      rc(8'h70, 32'hEE);
      rc(8'h70, 32'h00);
      rc(8'h74, 32'hA3);
      rc(8'h74, 32'h00);
      fork
         rc(8'h70, 32'h00);
         begin
            @(posedge clk);
            fe <= 8'h02;
            @(posedge clk);
            fe <= 8'h00;
         end
      join
      rc(8'h70, 32'h02);
      rc(8'hC4, 32'h07);
      host.acc(1'h1, 8'hC8, 32'h7, q);
      rc(8'hC4, 32'h00);
      host.acc(1'h1, 8'hC0, 32'h4, q);
      rc(8'hC0, 32'h04);
      chk(irq, 32'h0);
      pulse(8'h00, 8'h01);
      chk(irq, 32'h1);
      host.acc(1'h1, 8'hC8, 32'h4, q);
      repeat (2) @(posedge clk);
      chk(irq, 32'h0);
      host.acc(1'h1, 8'hC0, 32'h0, q);
      pulse(8'h00, 8'h01);
      chk(irq, 32'h0);
      // mid-run reset with the bus idle
      reset_n <= 1'h0;
      repeat (2) @(posedge clk);
      chk(irq, 32'h0);
      chk(wt, 32'h1);
      chk(rdd, 32'h0);
      reset_n <= 1'h1;
      @(posedge clk);
      rc(8'h6C, 32'h01);
      rc(8'hC4, 32'h01);
      rc(8'h54, 32'h00);
      rc(8'h58, 32'h00);
      rc(8'h5C, 32'h00);
      rc(8'h68, 32'h00);
      rc(8'h74, 32'h00);
      stop_test();
   end
endmodule
